// ===== hw/fpla_delay_count.sv
// loadable down-counter that flags expiry
`timescale 1ns/1ps
module fpla_delay_count #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_count,
  output logic o_expired
);
  logic [WIDTH-1:0] count_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= '0;
    end else if (i_load) begin
      count_q <= i_count;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end
  // expiry depends on the count alone, so a caller may reload on expiry without a loop
  assign o_expired = (count_q == '0);
endmodule : fpla_delay_count

// ===== hw/fpla_prog_defs.svh
// timing counts and field positions for the fuse programmer
`ifndef FPLA_PROG_DEFS_SVH
`define FPLA_PROG_DEFS_SVH
`define CLK_PERIOD_NS 10
`define NUM_INPUTS 16
`define NUM_TERMS 48
`define NUM_OUTPUTS 8
`define T_SETTLE_NS 3000
`define T_SETTLE_CYC ((`T_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_READ_NS 1000
`define T_READ_CYC ((`T_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RAMP_NS 150000
`define T_RAMP_CYC (`T_RAMP_NS / `CLK_PERIOD_NS)
`define POL_SEL_MASK 16'h003F
`endif

// ===== hw/fpla_prog_pkg.sv
// types for the fuse programmer
package fpla_prog_pkg;
  typedef enum logic [2:0] {
    OP_PROG_PRODUCT = 3'h0,
    OP_VERIFY_PRODUCT = 3'h1,
    OP_PROG_SUM = 3'h2,
    OP_VERIFY_SUM = 3'h3,
    OP_PROG_POLARITY = 3'h4,
    OP_VERIFY_POLARITY = 3'h5
  } op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_ACT = 3'h3,
    ST_READ2 = 3'h2,
    ST_DONE = 3'h6
  } state_type;
endpackage : fpla_prog_pkg

// ===== hw/fpla_programmer.sv
// host-side controller that programs and verifies the fuse array through its pins
// Rules of the fuse array and its programming steps
// [R1] a blank part has all cells intact, inverting buffers, outputs HIGH
// [R2] blank product term is one; blowing a cell adds that literal
// [R3] outputs are sums of up to 48 products of up to 16 literals
// [R4] blow just one input cell per programming step
// [R5] product term code on outputs 7..2, output 7 least significant
// [R6] raise inputs, chip select to program level, lower chosen input, ramp
// [R7] product verify reads output 0 with input HIGH then LOW
// [R8] product verify result ignores polarity; output 0 is open collector
// [R9] full verify runs at high then low supply; post-ramp check high only; here each verify request runs at its one requested supply level
// [R10] summing cell adds term m to output n's OR, n chosen by buffer
// [R11] sum program: term code on inputs 5..0, 15 and 14 HIGH, ramp one output
// [R12] sum verify: inputs 15,13 HIGH; LOW unprogrammed, HIGH programmed
// [R13] polarity program: inputs 5..0 and 15 HIGH, others raised, ramp one output
// [R14] polarity verify: chip select LOW; HIGH means still inverting
// [R15] polarity verify: LOW means programmed non-inverting
// [R16] chip select HIGH disables outputs in normal read
`timescale 1ns/1ps
`include "fpla_prog_defs.svh"
module fpla_programmer #(
  parameter int RAMP_CYC = `T_RAMP_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire fpla_prog_pkg::op_type i_op,
  input wire logic [5:0] i_term,
  input wire logic [3:0] i_input,
  input wire logic i_complement,
  input wire logic [2:0] i_output,
  input wire logic i_low_supply,
  input wire logic i_blown,
  input wire logic [7:0] i_dev_out,
  output logic o_busy,
  output logic o_done,
  output logic [1:0] o_cell,
  output logic o_result,
  output logic [15:0] o_in_level,
  output logic [15:0] o_in_high_v,
  output logic [7:0] o_out_level,
  output logic [7:0] o_out_oe,
  output logic o_cs_level,
  output logic o_cs_high_v,
  output logic o_ramp_vp,
  output logic [7:0] o_ramp_out,
  output logic o_vcc_low
);
  ////////////////////////////////////////////////////////////////
  fpla_prog_pkg::state_type state_q;
  fpla_prog_pkg::op_type op_q;
  logic [5:0] term_q;
  logic [3:0] in_q;
  logic comp_q;
  logic [2:0] outsel_q;
  logic first_q;
  logic low_q;
  logic load;
  logic expired;
  logic [17:0] load_val;
  logic is_prog;

  assign is_prog = (op_q == fpla_prog_pkg::OP_PROG_PRODUCT) || (op_q == fpla_prog_pkg::OP_PROG_SUM) ||
                   (op_q == fpla_prog_pkg::OP_PROG_POLARITY);

  fpla_delay_count #(.WIDTH(18)) u_delay (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(load),
    .i_count(load_val),
    .o_expired(expired)
  );

  ////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    load = 1'b0;
    load_val = 18'(`T_SETTLE_CYC);
    if (state_q == fpla_prog_pkg::ST_IDLE && i_start) begin
      load = 1'b1;
    end else if (state_q == fpla_prog_pkg::ST_SETUP && expired) begin
      load = 1'b1;
      load_val = is_prog ? 18'(RAMP_CYC) : 18'(`T_READ_CYC);
    end else if (state_q == fpla_prog_pkg::ST_ACT && expired && op_q == fpla_prog_pkg::OP_VERIFY_PRODUCT
                 && first_q) begin
      load = 1'b1;
      load_val = 18'(`T_READ_CYC);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= fpla_prog_pkg::ST_IDLE;
    end else begin
      case (state_q)
        fpla_prog_pkg::ST_IDLE: begin
          if (i_start) begin
            state_q <= fpla_prog_pkg::ST_SETUP;
          end
        end
        fpla_prog_pkg::ST_SETUP: begin
          if (expired) begin
            state_q <= fpla_prog_pkg::ST_ACT;
          end
        end
        fpla_prog_pkg::ST_ACT: begin
          // ramp stops on blow sense or time limit
          if ((is_prog && i_blown) || expired) begin
            state_q <= (op_q == fpla_prog_pkg::OP_VERIFY_PRODUCT && first_q) ? fpla_prog_pkg::ST_READ2
                       : fpla_prog_pkg::ST_DONE;
          end
        end
        fpla_prog_pkg::ST_READ2: begin
          state_q <= fpla_prog_pkg::ST_ACT;
        end
        fpla_prog_pkg::ST_DONE: begin
          state_q <= fpla_prog_pkg::ST_IDLE;
        end
        default: begin
          state_q <= fpla_prog_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // one cell per request; the request is captured at start
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_q <= fpla_prog_pkg::OP_VERIFY_POLARITY;
      term_q <= 6'h00;
      in_q <= 4'h0;
      comp_q <= 1'b0;
      outsel_q <= 3'h0;
      low_q <= 1'b0;
    end else if (state_q == fpla_prog_pkg::ST_IDLE && i_start) begin
      op_q <= i_op;
      term_q <= i_term; // R3
      in_q <= i_input; // R4
      comp_q <= i_complement;
      outsel_q <= i_output;
      low_q <= i_low_supply;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_q <= 1'b1;
    end else if (state_q == fpla_prog_pkg::ST_IDLE) begin
      first_q <= 1'b1;
    end else if (state_q == fpla_prog_pkg::ST_READ2) begin
      first_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // result capture
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cell <= 2'h3; // R1
      o_result <= 1'b0;
    end else if (state_q == fpla_prog_pkg::ST_ACT && expired && !is_prog) begin
      case (op_q)
        fpla_prog_pkg::OP_VERIFY_PRODUCT: begin
          // first read with input HIGH, second with input LOW
          if (first_q) begin
            o_cell[1] <= i_dev_out[0]; // R7 R8
          end else begin
            o_cell[0] <= i_dev_out[0]; // R7
            o_result <= !(o_cell[1] && i_dev_out[0]); // R2
          end
        end
        fpla_prog_pkg::OP_VERIFY_SUM: begin
          o_result <= i_dev_out[outsel_q]; // R12 R10
        end
        default: begin
          o_result <= !i_dev_out[outsel_q]; // R14 R15
        end
      endcase
    end
  end

  assign o_busy = (state_q != fpla_prog_pkg::ST_IDLE);
  assign o_done = (state_q == fpla_prog_pkg::ST_DONE);

  ////////////////////////////////////////////////////////////////
  // pin drive
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_in_level <= 16'h0000;
      o_in_high_v <= 16'h0000;
      o_out_level <= 8'hFF;
      o_out_oe <= 8'h00;
      o_cs_level <= 1'b1; // R16
      o_cs_high_v <= 1'b0;
      o_ramp_vp <= 1'b0;
      o_ramp_out <= 8'h00;
      o_vcc_low <= 1'b0;
    end else if (state_q == fpla_prog_pkg::ST_IDLE || state_q == fpla_prog_pkg::ST_DONE) begin
      o_in_level <= 16'h0000;
      o_in_high_v <= 16'h0000;
      o_out_oe <= 8'h00;
      o_cs_level <= 1'b1; // R16
      o_cs_high_v <= 1'b0;
      o_ramp_vp <= 1'b0;
      o_ramp_out <= 8'h00;
      o_vcc_low <= 1'b0;
    end else begin
      // program ops always at high supply; verify at the requested level
      o_vcc_low <= !is_prog && low_q; // R9
      o_in_level <= 16'hFFFF;
      o_out_oe <= 8'h00;
      o_ramp_vp <= 1'b0;
      o_ramp_out <= 8'h00;
      case (op_q)
        fpla_prog_pkg::OP_PROG_PRODUCT, fpla_prog_pkg::OP_VERIFY_PRODUCT: begin
          o_out_oe <= 8'hFC; // R5
          o_out_level <= {term_q[0], term_q[1], term_q[2], term_q[3], term_q[4], term_q[5], 2'b11}; // R5
          o_in_high_v <= 16'hFFFF;
          o_cs_level <= 1'b1;
          o_cs_high_v <= (op_q == fpla_prog_pkg::OP_PROG_PRODUCT); // R6 R7
          if (state_q != fpla_prog_pkg::ST_SETUP) begin
            o_in_high_v[in_q] <= 1'b0;
            if (op_q == fpla_prog_pkg::OP_PROG_PRODUCT) begin
              o_in_level[in_q] <= comp_q; // R6
              o_ramp_vp <= (state_q == fpla_prog_pkg::ST_ACT); // R6
            end else begin
              o_in_level[in_q] <= first_q; // R7
            end
          end
        end
        fpla_prog_pkg::OP_PROG_SUM, fpla_prog_pkg::OP_VERIFY_SUM: begin
          o_in_level <= {10'h3FF, term_q}; // R11
          o_in_high_v <= (op_q == fpla_prog_pkg::OP_PROG_SUM) ? 16'h3FC0 : 16'h5FC0; // R11 R12
          o_cs_high_v <= (op_q == fpla_prog_pkg::OP_PROG_SUM);
          o_cs_level <= (op_q == fpla_prog_pkg::OP_PROG_SUM); // R12
          if (op_q == fpla_prog_pkg::OP_PROG_SUM && state_q == fpla_prog_pkg::ST_ACT) begin
            o_ramp_out[outsel_q] <= 1'b1; // R11 R10
          end
        end
        default: begin
          o_in_level <= 16'hFFFF; // R13
          o_in_high_v <= (op_q == fpla_prog_pkg::OP_PROG_POLARITY) ? 16'h7FC0 : 16'h9FC0; // R13 R14
          o_cs_level <= (op_q == fpla_prog_pkg::OP_PROG_POLARITY); // R14
          o_cs_high_v <= (op_q == fpla_prog_pkg::OP_PROG_POLARITY);
          if (op_q == fpla_prog_pkg::OP_PROG_POLARITY && state_q == fpla_prog_pkg::ST_ACT) begin
            o_ramp_out[outsel_q] <= 1'b1; // R13
          end
        end
      endcase
    end
  end
endmodule : fpla_programmer

// ===== tb/fpla_model.sv
// behavioural fuse array answering the programmer's pins
`timescale 1ns/1ps
module fpla_model (
  input wire logic i_clk,
  input wire logic [15:0] i_in_level,
  input wire logic [15:0] i_in_high_v,
  input wire logic [7:0] i_out_level,
  input wire logic i_cs_level,
  input wire logic i_cs_high_v,
  input wire logic i_ramp_vp,
  input wire logic [7:0] i_ramp_out,
  output logic o_blown,
  output logic [7:0] o_dev_out
);
  logic [15:0] cell_t_q [64];
  logic [15:0] cell_c_q [64];
  logic [7:0] sum_q [64];
  logic [7:0] pol_q;
  logic [3:0] ramp_cnt_q;
  logic [5:0] pterm;
  logic [5:0] aterm;
  logic [15:0] sel;
  assign pterm = {i_out_level[2], i_out_level[3], i_out_level[4], i_out_level[5], i_out_level[6], i_out_level[7]};
  assign aterm = i_in_level[5:0];
  assign sel = ~i_in_high_v;
  initial begin
    for (int m = 0; m < 64; m++) begin
      cell_t_q[m] = 16'h0000;
      cell_c_q[m] = 16'h0000;
      sum_q[m] = 8'h00;
    end
    pol_q = 8'h00;
    ramp_cnt_q = 4'h0;
  end
  always @(posedge i_clk) begin
    ramp_cnt_q <= (i_ramp_vp || (|i_ramp_out)) ? ramp_cnt_q + 4'h1 : 4'h0;
    if (ramp_cnt_q == 4'h4 && i_cs_high_v) begin
      if (i_ramp_vp) begin
        cell_t_q[pterm] <= cell_t_q[pterm] | (sel & ~i_in_level);
        cell_c_q[pterm] <= cell_c_q[pterm] | (sel & i_in_level);
      end else if (!i_in_high_v[15] && !i_in_high_v[14]) sum_q[aterm] <= sum_q[aterm] | i_ramp_out;
      else if (!i_in_high_v[15]) pol_q <= pol_q | i_ramp_out;
    end
  end
  assign o_blown = ramp_cnt_q > 4'h4;
  always_comb begin
    o_dev_out = 8'hFF;
    if (i_in_high_v[15:13] == 3'b010 && !(|i_ramp_out)) o_dev_out = sum_q[aterm];
    else if (!i_cs_high_v && i_cs_level && !i_ramp_vp)
      o_dev_out[0] = !(|(sel & i_in_level & cell_c_q[pterm]) || |(sel & ~i_in_level & cell_t_q[pterm]));
    else if (!i_cs_level && !i_cs_high_v && i_in_high_v[15]) o_dev_out = ~pol_q;
  end
endmodule : fpla_model

// ===== tb/fpla_programmer_asserts.sv
// concurrent checks on the fuse programmer's pin sequencing
`timescale 1ns/1ps
`include "fpla_prog_defs.svh"
module fpla_programmer_asserts #(
  parameter int RAMP_CYC = `T_RAMP_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire fpla_prog_pkg::op_type i_op,
  input wire logic [5:0] i_term,
  input wire logic i_low_supply,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [15:0] o_in_level,
  input wire logic [15:0] o_in_high_v,
  input wire logic [7:0] o_out_level,
  input wire logic [7:0] o_out_oe,
  input wire logic o_cs_level,
  input wire logic o_cs_high_v,
  input wire logic o_ramp_vp,
  input wire logic [7:0] o_ramp_out,
  input wire logic o_vcc_low
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  fpla_prog_pkg::op_type op_q;
  logic [5:0] term_q;
  logic low_q;
  int ramp_q;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_q <= fpla_prog_pkg::OP_PROG_PRODUCT;
      term_q <= 6'h00;
      low_q <= 1'b0;
    end else if (i_start && !o_busy) begin
      op_q <= i_op;
      term_q <= i_term;
      low_q <= i_low_supply;
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) ramp_q <= 0;
    else ramp_q <= (o_ramp_vp || (|o_ramp_out)) ? ramp_q + 1 : 0;
  end
  a_start_taken: assert property (i_start && !o_busy |=> o_busy) else $error("start not taken");
  a_done_pulse: assert property (o_done |=> !o_done && !o_busy) else $error("done not a single pulse");
  a_term_code: assert property (o_done && op_q inside {fpla_prog_pkg::OP_PROG_PRODUCT, fpla_prog_pkg::OP_VERIFY_PRODUCT}
    |-> o_out_oe[7:2] == 6'h3F && o_out_level[7:2] == {term_q[0], term_q[1], term_q[2], term_q[3], term_q[4],
    term_q[5]}) else $error("term code wrong");
  a_one_literal: assert property (o_ramp_vp |-> $countones(~o_in_high_v) == 1 && o_cs_high_v
    && !(|o_ramp_out)) else $error("product ramp setup wrong");
  a_sum_setup: assert property (o_done && op_q == fpla_prog_pkg::OP_PROG_SUM |-> o_in_level[5:0] == term_q
    && o_in_level[15:14] == 2'b11 && o_in_high_v[15:13] == 3'b001 && o_cs_high_v) else $error("sum setup wrong");
  a_sum_verify: assert property (o_done && op_q == fpla_prog_pkg::OP_VERIFY_SUM |-> o_in_level[5:0] == term_q
    && o_in_level[15] && o_in_level[13] && o_in_high_v[15:13] == 3'b010 && !(|o_ramp_out))
    else $error("sum verify setup wrong");
  a_pol_verify: assert property (o_done && op_q == fpla_prog_pkg::OP_VERIFY_POLARITY |-> !o_cs_level && !o_cs_high_v
    && o_in_level[5:0] == 6'h3F && o_in_high_v[15:13] == 3'b100) else $error("polarity verify setup wrong");
  a_pv_cs_high: assert property (o_done && op_q == fpla_prog_pkg::OP_VERIFY_PRODUCT |-> o_cs_level
    && !o_cs_high_v && !o_ramp_vp) else $error("product verify chip select wrong");
  a_ramp_bound: assert property (ramp_q <= RAMP_CYC + 1) else $error("ramp too long");
  a_one_output: assert property ($onehot0(o_ramp_out) && !(o_ramp_vp && (|o_ramp_out))) else $error("several ramps");
  a_supply_level: assert property (o_done && op_q inside {fpla_prog_pkg::OP_VERIFY_PRODUCT, fpla_prog_pkg::OP_VERIFY_SUM,
    fpla_prog_pkg::OP_VERIFY_POLARITY} |-> o_vcc_low == low_q) else $error("supply level wrong");
  a_ramp_high_vcc: assert property (o_ramp_vp || (|o_ramp_out) |-> !o_vcc_low) else $error("ramp at low supply");
endmodule : fpla_programmer_asserts
bind fpla_programmer fpla_programmer_asserts #(.RAMP_CYC(RAMP_CYC)) fpla_programmer_asserts_i (.*);

// ===== tb/testbench.sv
// scenario testbench for the fuse programmer against the array model
`timescale 1ns/1ps
module testbench;
  logic i_clk, i_reset_n, i_start, i_complement, i_low_supply, i_blown, o_busy, o_done, o_result;
  logic o_cs_level, o_cs_high_v, o_ramp_vp, o_vcc_low;
  fpla_prog_pkg::op_type i_op;
  logic [5:0] i_term;
  logic [3:0] i_input;
  logic [2:0] i_output;
  logic [7:0] i_dev_out, o_out_level, o_out_oe, o_ramp_out;
  logic [1:0] o_cell;
  logic [15:0] o_in_level, o_in_high_v;
  int fails, check_count, cycles;
  fpla_programmer #(.RAMP_CYC(50)) fpla_programmer_i (.*);
  fpla_model fpla_model_i (.i_clk(i_clk), .i_in_level(o_in_level), .i_in_high_v(o_in_high_v),
    .i_out_level(o_out_level), .i_cs_level(o_cs_level), .i_cs_high_v(o_cs_high_v), .i_ramp_vp(o_ramp_vp),
    .i_ramp_out(o_ramp_out), .o_blown(i_blown), .o_dev_out(i_dev_out));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk_bit(string name, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic chk_cell(string name, logic [1:0] exp, logic [1:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_cell
  task automatic run(fpla_prog_pkg::op_type op, logic [5:0] term, logic [3:0] inp, logic comp, logic [2:0] outp,
    logic low);
    @(negedge i_clk);
    i_op = op;
    i_term = term;
    i_input = inp;
    i_complement = comp;
    i_output = outp;
    i_low_supply = low;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    while (o_done !== 1'b1) @(negedge i_clk);
  endtask : run
  task automatic t_blank_product();
    for (int s = 0; s < 2; s++) begin
      run(fpla_prog_pkg::OP_VERIFY_PRODUCT, 6'h2F, 4'hF, 1'b0, 3'h0, s[0]);
      chk_cell("blank cell", 2'h3, o_cell);
      chk_bit("blank programmed", 1'b0, o_result);
    end
  endtask : t_blank_product
  task automatic t_product();
    run(fpla_prog_pkg::OP_PROG_PRODUCT, 6'h00, 4'h0, 1'b0, 3'h0, 1'b0);
    run(fpla_prog_pkg::OP_VERIFY_PRODUCT, 6'h00, 4'h0, 1'b0, 3'h0, 1'b0);
    chk_cell("true cell", 2'h2, o_cell);
    chk_bit("true programmed", 1'b1, o_result);
    run(fpla_prog_pkg::OP_PROG_PRODUCT, 6'h05, 4'hF, 1'b1, 3'h0, 1'b0);
    run(fpla_prog_pkg::OP_VERIFY_PRODUCT, 6'h05, 4'hF, 1'b0, 3'h0, 1'b1);
    chk_cell("compl cell", 2'h1, o_cell);
    run(fpla_prog_pkg::OP_VERIFY_PRODUCT, 6'h05, 4'hE, 1'b0, 3'h0, 1'b0);
    chk_cell("neighbour cell", 2'h3, o_cell);
    run(fpla_prog_pkg::OP_PROG_PRODUCT, 6'h00, 4'h0, 1'b1, 3'h0, 1'b0);
    run(fpla_prog_pkg::OP_VERIFY_PRODUCT, 6'h00, 4'h0, 1'b0, 3'h0, 1'b0);
    chk_cell("both cell", 2'h0, o_cell);
  endtask : t_product
  task automatic t_sum();
    run(fpla_prog_pkg::OP_PROG_SUM, 6'h21, 4'h0, 1'b0, 3'h3, 1'b0);
    run(fpla_prog_pkg::OP_VERIFY_SUM, 6'h21, 4'h0, 1'b0, 3'h3, 1'b1);
    chk_bit("sum set", 1'b1, o_result);
    run(fpla_prog_pkg::OP_VERIFY_SUM, 6'h21, 4'h0, 1'b0, 3'h4, 1'b0);
    chk_bit("sum other output", 1'b0, o_result);
    run(fpla_prog_pkg::OP_VERIFY_SUM, 6'h20, 4'h0, 1'b0, 3'h3, 1'b0);
    chk_bit("sum other term", 1'b0, o_result);
  endtask : t_sum
  task automatic t_polarity();
    run(fpla_prog_pkg::OP_VERIFY_POLARITY, 6'h00, 4'h0, 1'b0, 3'h0, 1'b0);
    chk_bit("polarity blank", 1'b0, o_result);
    run(fpla_prog_pkg::OP_PROG_POLARITY, 6'h00, 4'h0, 1'b0, 3'h0, 1'b0);
    run(fpla_prog_pkg::OP_VERIFY_POLARITY, 6'h00, 4'h0, 1'b0, 3'h0, 1'b1);
    chk_bit("polarity set", 1'b1, o_result);
    run(fpla_prog_pkg::OP_VERIFY_PRODUCT, 6'h00, 4'h0, 1'b0, 3'h0, 1'b0);
    chk_cell("cell after polarity", 2'h0, o_cell);
  endtask : t_polarity
  initial begin
    {i_reset_n, i_start, i_complement, i_low_supply, i_term, i_input, i_output} = '0;
    i_op = fpla_prog_pkg::OP_PROG_PRODUCT;
    repeat (12) @(negedge i_clk);
    chk_bit("reset chip select", 1'b1, o_cs_level);
    i_reset_n = 1'b1;
    t_blank_product();
    t_product();
    t_sum();
    t_polarity();
    finish_test();
  end
endmodule : testbench
